// file: bench/rf_switch_power_state_chk.sv
`default_nettype none
module rf_switch_power_state_chk (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       vioPin,
  input wire logic [3:0] stateOneHot,
  input wire logic       slaveActive,
  input wire logic       chargePumpOn,
  input wire logic       regsAtDefault,
  input wire logic       pathValid,
  input wire logic [5:0] pathEnable
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // state rules
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [11:0] cpCnt_r;
  logic        vioPrev_r;
  logic        rdyArm_r;
  logic [11:0] rdyCnt_r;
  // cycles since pump came on
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst) cpCnt_r <= 12'h000;
    else cpCnt_r <= chargePumpOn ? cpCnt_r + 12'h001 : 12'h000;
  // cycles from supply up in shutdown to usable paths;
  // counted, a range this long would be slow to check
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vioPrev_r <= 1'b0;
      rdyArm_r  <= 1'b0;
      rdyCnt_r  <= 12'h000;
    end else begin
      vioPrev_r <= vioPin;
      if (!vioPin || pathValid) begin
        rdyArm_r <= 1'b0;
        rdyCnt_r <= 12'h000;
      end else if (!vioPrev_r && stateOneHot[0]) begin
        rdyArm_r <= 1'b1;
        rdyCnt_r <= 12'h000;
      end else if (rdyArm_r) begin
        rdyCnt_r <= rdyCnt_r + 12'h001;
      end
    end
  end
  sequence s_boot;
    stateOneHot[1] && regsAtDefault ##1 stateOneHot[2];
  endsequence
  property p_one; $onehot(stateOneHot); endproperty
  a_one: assert property (p_one) else $error("state not one-hot");
  property p_slave; slaveActive == !stateOneHot[0]; endproperty
  a_slave: assert property (p_slave) else $error("slave state");
  property p_pump; chargePumpOn == stateOneHot[2]; endproperty
  a_pump: assert property (p_pump) else $error("pump state");
  property p_boot; $rose(stateOneHot[1]) |-> s_boot; endproperty
  a_boot: assert property (p_boot) else $error("startup steps");
  property p_defl; regsAtDefault |-> stateOneHot[1]; endproperty
  a_defl: assert property (p_defl) else $error("defaults outside");
  property p_valid; pathValid |-> chargePumpOn; endproperty
  a_valid: assert property (p_valid) else $error("valid w/o pump");
  property p_drop; $fell(chargePumpOn) |=> pathEnable == 6'h00; endproperty
  a_drop: assert property (p_drop) else $error("paths left on");
  property p_settle;
    $rose(pathValid) |-> cpCnt_r >= 12'h703 && cpCnt_r <= 12'h70D;
  endproperty
  a_settle: assert property (p_settle) else $error("settle time");
  property p_ready; rdyArm_r |-> rdyCnt_r < 12'h7D0; endproperty
  a_ready: assert property (p_ready) else $error("not ready");
  property p_off; !vioPin [*4] |-> stateOneHot[0]; endproperty
  a_off: assert property (p_off) else $error("no shutdown");
endmodule // rf_switch_power_state_chk
bind rf_switch_power_state_control rf_switch_power_state_chk u_chk (
  .clk(clk), .sys_rst(sys_rst), .vioPin(vioPin), .stateOneHot(stateOneHot),
  .slaveActive(slaveActive), .chargePumpOn(chargePumpOn),
  .regsAtDefault(regsAtDefault), .pathValid(pathValid),
  .pathEnable(pathEnable));
`default_nettype wire

// file: bench/rf_switch_power_state_control_tb_top.sv
`default_nettype none
module rf_switch_power_state_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       vioPin = 1'b0;
  wire        sclkPin, sdataPin, slaveActive, chargePumpOn;
  wire        regsAtDefault, pathValid;
  wire  [3:0] stateOneHot;
  wire  [5:0] pathEnable;
  int         n_checks, n_mismatch, k;
  // switch code beside expected path drive
  logic [13:0] rows [8] = '{{8'h01, 6'h01}, {8'h02, 6'h02}, {8'h03, 6'h04},
    {8'h04, 6'h08}, {8'h05, 6'h10}, {8'h06, 6'h20}, {8'h07, 6'h00},
    {8'h00, 6'h00}};
  always #5 clk = ~clk;
  rffe_master_model m (.sclkPin(sclkPin), .sdataPin(sdataPin));
  rf_switch_power_state_control #(.USID(4'h7)) DUT (
    .clk(clk), .sys_rst(sys_rst), .vioPin(vioPin), .sclkPin(sclkPin),
    .sdataPin(sdataPin), .stateOneHot(stateOneHot),
    .slaveActive(slaveActive), .chargePumpOn(chargePumpOn),
    .regsAtDefault(regsAtDefault), .pathValid(pathValid),
    .pathEnable(pathEnable));
  // ----
  // helpers
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait, longer than the ready limit
  task automatic settle(output int c);
    c = 0;
    while (pathValid !== 1'b1 && c < 2100) begin
      @(negedge clk);
      c++;
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk({stateOneHot, pathEnable}, {4'h1, 6'h00});
    @(posedge clk) vioPin <= 1'b1;
    settle(k);
    chk(k <= 2000, 1'b1);
    chk({slaveActive, chargePumpOn}, 2'h3);
    foreach (rows[i]) begin
      m.send(5'h00, rows[i][13:6]);
      repeat (5) @(negedge clk);
      chk(pathEnable, rows[i][5:0]);
    end
    m.send(5'h1C, 8'h80);
    repeat (5) @(negedge clk);
    chk({stateOneHot, slaveActive, chargePumpOn, pathEnable}, 12'h880);
    m.send(5'h00, 8'h03);
    m.send(5'h1C, 8'h00);
    repeat (5) @(negedge clk);
    chk({pathValid, pathEnable}, 7'h00);
    settle(k);
    repeat (2) @(negedge clk);
    chk({stateOneHot, pathEnable}, {4'h4, 6'h04});
    m.send(5'h1C, 8'hC0);
    repeat (5) @(negedge clk);
    chk(stateOneHot, 4'h4);
    m.send(5'h1C, 8'h40);
    settle(k);
    repeat (2) @(negedge clk);
    chk({stateOneHot, pathEnable}, {4'h4, 6'h00});
    // reset in mid-run with the supply still up
    @(posedge clk) sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk({stateOneHot, pathValid, pathEnable}, {4'h1, 1'b0, 6'h00});
    settle(k);
    chk(k <= 2000, 1'b1);
    @(posedge clk) vioPin <= 1'b0;
    repeat (5) @(negedge clk);
    chk({stateOneHot, slaveActive, chargePumpOn}, 6'h04);
    m.send(5'h1C, 8'h80);
    chk(stateOneHot, 4'h1);
    summarize;
  end
  initial begin
    #300us;
    n_mismatch++;
    summarize;
  end
endmodule // rf_switch_power_state_control_tb_top
`default_nettype wire

// file: bench/rffe_master_model.sv
`default_nettype none
module rffe_master_model #(
  parameter logic [3:0] SLAVE_ID = 4'h7  // arbitrary
) (
  output var logic sclkPin,
  output var logic sdataPin
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // write frames
  // ----
  // clock stands low between frames; data parked low
  initial begin
    sclkPin = 1'b0;
    sdataPin = 1'b0;
  end
  task automatic send(input logic [4:0] addr, input logic [7:0] data);
    logic [21:0] frm;
    frm = {SLAVE_ID, 3'h2, addr, ~^{SLAVE_ID, 3'h2, addr}, data, ~^data};
    sdataPin = 1'b1;
    #160;
    sdataPin = 1'b0;
    #160;
    for (int i = 21; i >= 0; i--) begin
      sclkPin = 1'b1;
      sdataPin = frm[i];
      #80;
      sclkPin = 1'b0;
      #80;
    end
    sclkPin = 1'b1;
    sdataPin = 1'b0;
    #80;
    sclkPin = 1'b0;
    #80;
  endtask
endmodule // rffe_master_model
`default_nettype wire

// file: logic/rf_switch_power_state_control.v
// Behaviour
// - exactly one of shutdown, startup, active, low power is held
// - state moves on power register writes or interface supply change; startup goes on to active after one cycle by itself
// - startup loads every slave register with its default value
// - slave off only in shutdown; charge pump on only in active
// - switch paths follow commands only in active state
// - ready within 20 us of both supplies being applied
`include "rf_switch_power_state_regs.vh"
`default_nettype none

module rf_switch_power_state_control #(
  parameter [3:0] USID = 4'h7  // arbitrary slave id
) (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       vioPin,
  input  wire       sclkPin,
  input  wire       sdataPin,
  output wire [3:0] stateOneHot,
  output wire       slaveActive,
  output wire       chargePumpOn,
  output wire       regsAtDefault,
  output wire       pathValid,
  output wire [5:0] pathEnable
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [3:0] ST_SHUT  = 4'h1;
  localparam [3:0] ST_START = 4'h2;
  localparam [3:0] ST_ACT   = 4'h4;
  localparam [3:0] ST_LOW   = 4'h8;
  localparam integer SETTLE_INT = `CP_SETTLE_CYC;
  localparam [11:0]  SETTLE_CYC = SETTLE_INT[11:0];

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function oddOk;
    input [12:0] bits;
    begin
      oddOk = ^bits;
    end
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [1:0] vioSync_r;
  reg [1:0] sclkSync_r;
  reg [1:0] sdataSync_r;
  reg       sclkPrev_r;
  reg       sdataPrev_r;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vioSync_r   <= 2'h0;
      sclkSync_r  <= 2'h0;
      sdataSync_r <= 2'h0;
      sclkPrev_r  <= 1'b0;
      sdataPrev_r <= 1'b0;
    end else begin
      vioSync_r   <= {vioSync_r[0], vioPin};
      sclkSync_r  <= {sclkSync_r[0], sclkPin};
      sdataSync_r <= {sdataSync_r[0], sdataPin};
      sclkPrev_r  <= sclkSync_r[1];
      sdataPrev_r <= sdataSync_r[1];
    end
  end

  wire vioOn    = vioSync_r[1];
  wire sclk     = sclkSync_r[1];
  wire sdata    = sdataSync_r[1];
  wire sclkFall = sclkPrev_r & ~sclk;
  // start: data falls while clock low and outside a frame
  wire seqStart = ~sclk & ~sclkPrev_r & sdataPrev_r & ~sdata;

  // ----------------------------------------
  // frame receiver, write commands only
  // ----------------------------------------
  reg        inFrame_r;
  reg [4:0]  bitCnt_r;
  reg [21:0] shift_r;
  reg        frameDone_r;
  reg [3:0]  state_r;

  // a frame cut by a state change is dropped, never resumed
  wire rxEnable = (state_r == ST_ACT) | (state_r == ST_LOW);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      inFrame_r   <= 1'b0;
      bitCnt_r    <= 5'h00;
      shift_r     <= 22'h000000;
      frameDone_r <= 1'b0;
    end else begin
      frameDone_r <= 1'b0;
      if (!rxEnable) begin
        inFrame_r <= 1'b0;
        bitCnt_r  <= 5'h00;
      end else if (!inFrame_r) begin
        if (seqStart) begin
          inFrame_r <= 1'b1;
          bitCnt_r  <= 5'h00;
        end
      end else if (sclkFall) begin
        // slave samples on the falling clock edge
        shift_r  <= {shift_r[20:0], sdata};
        bitCnt_r <= bitCnt_r + 5'h01;
        if (bitCnt_r == `FRAME_BITS - 5'h01) begin
          inFrame_r   <= 1'b0;
          frameDone_r <= 1'b1;
        end
      end
    end
  end

  wire [4:0] frAddr = shift_r[`FR_ADDR_HI:`FR_ADDR_LO];
  wire [7:0] frData = shift_r[`FR_DATA_HI:`FR_DATA_LO];
  // odd parity over command half and over data byte
  wire cmdParOk = oddOk(shift_r[21:9]);
  wire datParOk = oddOk({4'h0, shift_r[8:0]});
  // a bad parity drops the whole frame, nothing is half written
  wire frWrite = frameDone_r
               & (shift_r[`FR_SA_HI:`FR_SA_LO] == USID)
               & (shift_r[`FR_CMD_HI:`FR_CMD_LO] == `CMD_WRITE)
               & cmdParOk
               & datParOk;
  wire pwrWrite = frWrite & (frAddr == `POWER_STATE_REG_ADDR);
  wire swWrite  = frWrite & (frAddr == `SWITCH_REG_ADDR);
  wire [1:0] pwrCode = frData[`PM_FIELD_HI:`PM_FIELD_LO];

  // ----------------------------------------
  // operating state
  // ----------------------------------------
  reg [3:0]  state_nxt;
  reg [1:0]  powerReg_r;
  reg [7:0]  switchReg_r;
  reg [11:0] settle_r;
  reg [5:0]  pathEn_r;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_SHUT: begin
        if (vioOn) begin
          state_nxt = ST_START;
        end
      end
      ST_START: begin
        state_nxt = vioOn ? ST_ACT : ST_SHUT;
      end
      ST_ACT, ST_LOW: begin
        if (!vioOn) begin
          state_nxt = ST_SHUT;
        end else if (pwrWrite) begin
          case (pwrCode)
            `PM_ACTIVE:  state_nxt = ST_ACT;
            `PM_STARTUP: state_nxt = ST_START;
            `PM_LOWPWR:  state_nxt = ST_LOW;
            default:     state_nxt = state_r;   // reserved code ignored
          endcase
        end
      end
      default: state_nxt = ST_SHUT;
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r     <= ST_SHUT;
      powerReg_r  <= `POWER_REG_DEFAULT;
      switchReg_r <= `SWITCH_REG_DEFAULT;
      settle_r    <= 12'h000;
      pathEn_r    <= 6'h00;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_START) begin
        powerReg_r  <= `POWER_REG_DEFAULT;
        switchReg_r <= `SWITCH_REG_DEFAULT;
      end else begin
        if (pwrWrite && pwrCode != 2'h3) powerReg_r <= pwrCode;
        if (swWrite) switchReg_r <= frData;
      end
      // pump restarts on every entry to active
      // pump output is not sensed; a fixed count stands in for it
      if (state_nxt != ST_ACT) begin
        settle_r <= SETTLE_CYC;
      end else if (settle_r != 12'h000) begin
        settle_r <= settle_r - 12'h001;
      end
      if (state_r == ST_ACT && settle_r == 12'h000) begin
        case (switchReg_r)
          8'h01:   pathEn_r <= 6'h01;
          8'h02:   pathEn_r <= 6'h02;
          8'h03:   pathEn_r <= 6'h04;
          8'h04:   pathEn_r <= 6'h08;
          8'h05:   pathEn_r <= 6'h10;
          8'h06:   pathEn_r <= 6'h20;
          default: pathEn_r <= 6'h00;
        endcase
      end else begin
        pathEn_r <= 6'h00;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign stateOneHot   = state_r;
  assign slaveActive   = (state_r != ST_SHUT);
  assign chargePumpOn  = (state_r == ST_ACT);
  assign regsAtDefault = (state_r == ST_START);
  assign pathValid     = (state_r == ST_ACT) & (settle_r == 12'h000);
  assign pathEnable    = pathEn_r;

endmodule // rf_switch_power_state_control

`default_nettype wire

// file: logic/rf_switch_power_state_regs.vh
`ifndef RF_SWITCH_POWER_STATE_REGS_VH
`define RF_SWITCH_POWER_STATE_REGS_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define CLK_PERIOD_NS       10
`define READY_MAX_US        20
`define CP_SETTLE_US        18
`define CP_SETTLE_CYC       ((`CP_SETTLE_US * 1000) / `CLK_PERIOD_NS)

// ----------------------------------------
// serial slave register addresses
// ----------------------------------------
`define SWITCH_REG_ADDR     5'h00
`define POWER_STATE_REG_ADDR 5'h1C

// ----------------------------------------
// power state register field and codes
// ----------------------------------------
`define PM_FIELD_HI         7
`define PM_FIELD_LO         6
`define PM_ACTIVE           2'h0
`define PM_STARTUP          2'h1
`define PM_LOWPWR           2'h2

// ----------------------------------------
// reset values of slave registers
// ----------------------------------------
`define SWITCH_REG_DEFAULT  8'h00
`define POWER_REG_DEFAULT   2'h0

// ----------------------------------------
// frame layout, msb first after start
// ----------------------------------------
`define FRAME_BITS          5'h16
`define CMD_WRITE           3'h2
`define FR_SA_HI            21
`define FR_SA_LO            18
`define FR_CMD_HI           17
`define FR_CMD_LO           15
`define FR_ADDR_HI          14
`define FR_ADDR_LO          10
`define FR_DATA_HI          8
`define FR_DATA_LO          1

`endif
